/* File: inc/host_irq_defines.svh */
// offsets, field positions and reset values for the host interrupt and mailbox block
`ifndef HOST_IRQ_DEFINES_SVH
`define HOST_IRQ_DEFINES_SVH
`define REG_ADDR_W 12
`define HIE_OFFSET 12'h4E4
`define MBOX_OFFSET 12'h4E8
`define LIE_OFFSET 12'h4F4
`define EVT_W 10
`define ST_MSB 9
`define EN_LSB 16
`define EN_MSB 25
`define MBOX_IRQ_BIT 24
`define MBOX_B1_MSB 15
`define MBOX_B0_LSB 0
`define LIE_MBOX_ST_BIT 3
`define LIE_MBOX_EN_BIT 19
`define ST_RSVD_MASK 10'h004
`define ST_LIVE_MASK 10'h0C0
`define ST_LIVE_IN_BIT 6
`define ST_LIVE_OUT_BIT 7
`define EN_RESET 10'h000
`define ST_RESET 10'h000
`define MBOX_RESET 16'h0000
`define RDATA_RESET 32'h0000_0000
`endif

/* File: inc/host_irq_pkg.sv */
// types shared by the host interrupt and mailbox block
package host_irq_pkg;
	typedef logic [9:0] event_vec_t;
	typedef logic [15:0] mbox_data_t;
	typedef logic [31:0] word_t;
	typedef logic [11:0] reg_addr_t;
	typedef enum logic [1:0] {
		SEL_NONE = 2'h0,
		SEL_HIE = 2'h1,
		SEL_MBOX = 2'h3,
		SEL_LIE = 2'h2
	} reg_sel_t;
endpackage : host_irq_pkg

/* File: rtl/event_latch.sv */
// sticky event bits: hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
module event_latch #(
	parameter int WIDTH = 10
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clr,
	output logic [WIDTH-1:0] q
);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= set | (q & ~clr);
		end
	end
endmodule : event_latch

/* File: rtl/host_interrupt_and_mailbox.sv */
// host interrupt enable/status register and host-to-local mailbox
`timescale 1ns/1ps
`include "host_irq_defines.svh"

module host_interrupt_and_mailbox (
	input wire logic clock,
	input wire logic nrst,
	input wire logic soft_rst,
	input wire logic host_wr_en,
	input wire logic host_rd_en,
	input wire logic [11:0] host_addr,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	input wire logic local_wr_en,
	input wire logic local_rd_en,
	input wire logic [11:0] local_addr,
	input wire logic [31:0] local_wdata,
	output logic [31:0] local_rdata,
	input wire logic evt_local_ovf,
	input wire logic evt_pci_ovf,
	input wire logic evt_l2h_mailbox,
	input wire logic evt_ext_signal,
	input wire logic evt_dma_done,
	input wire logic inbound_q_bit3,
	input wire logic outbound_q_bit3,
	input wire logic evt_target_abort,
	input wire logic evt_master_abort,
	output logic host_irq,
	output logic local_irq
);
	function automatic host_irq_pkg::reg_sel_t decode(input logic [11:0] addr);
		unique case (addr)
			`HIE_OFFSET: decode = host_irq_pkg::SEL_HIE;
			`MBOX_OFFSET: decode = host_irq_pkg::SEL_MBOX;
			`LIE_OFFSET: decode = host_irq_pkg::SEL_LIE;
			default: decode = host_irq_pkg::SEL_NONE;
		endcase
	endfunction : decode

	host_irq_pkg::reg_sel_t host_sel;
	host_irq_pkg::reg_sel_t local_sel;
	host_irq_pkg::event_vec_t enable_reg;
	host_irq_pkg::event_vec_t latched;
	host_irq_pkg::event_vec_t live_reg;
	host_irq_pkg::event_vec_t status;
	host_irq_pkg::event_vec_t set_vec;
	host_irq_pkg::event_vec_t clr_vec;
	host_irq_pkg::mbox_data_t mbox_reg;
	logic lie_en_reg;
	logic lie_st;
	logic lie_set;
	logic lie_clr;
	logic host_hie_wr;
	logic host_mbox_wr;
	logic local_lie_wr;

	assign host_sel = decode(host_addr);
	assign local_sel = decode(local_addr);
	assign host_hie_wr = host_wr_en && (host_sel == host_irq_pkg::SEL_HIE);
	assign host_mbox_wr = host_wr_en && (host_sel == host_irq_pkg::SEL_MBOX);
	assign local_lie_wr = local_wr_en && (local_sel == host_irq_pkg::SEL_LIE);

	// event order from bit 0; reserved bit 2 and live bits 6/7 never latch
	assign set_vec = {evt_master_abort, evt_target_abort, 2'b00, evt_dma_done,
		evt_ext_signal, evt_l2h_mailbox, 1'b0, evt_pci_ovf, evt_local_ovf};
	assign clr_vec = host_hie_wr ? (host_wdata[`ST_MSB:0] & ~`ST_LIVE_MASK) : '0;

	event_latch #(
		.WIDTH(`EVT_W)
	) u_host_status (
		.clock(clock),
		.nrst(nrst),
		.set(set_vec),
		.clr(clr_vec),
		.q(latched)
	);

	// live mirrors of the queue not-empty flags, read only here
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			live_reg <= `ST_RESET;
		end else begin
			live_reg <= '0;
			live_reg[`ST_LIVE_IN_BIT] <= inbound_q_bit3;
			live_reg[`ST_LIVE_OUT_BIT] <= outbound_q_bit3;
		end
	end

	assign status = (latched & ~`ST_RSVD_MASK) | (live_reg & `ST_LIVE_MASK);

	// host enables; soft reset does not touch them
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= `EN_RESET;
		end else if (host_hie_wr) begin
			enable_reg <= host_wdata[`EN_MSB:`EN_LSB] & ~`ST_RSVD_MASK;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			host_irq <= 1'b0;
		end else begin
			host_irq <= |(status & enable_reg);
		end
	end

	// mailbox data bytes written by the host
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mbox_reg <= `MBOX_RESET;
		end else if (host_mbox_wr) begin
			mbox_reg <= host_wdata[`MBOX_B1_MSB:`MBOX_B0_LSB];
		end
	end

	// local mailbox event: set by host bit 24, cleared by local write-one or soft reset
	assign lie_set = host_mbox_wr && host_wdata[`MBOX_IRQ_BIT];
	assign lie_clr = soft_rst || (local_lie_wr && local_wdata[`LIE_MBOX_ST_BIT]);

	event_latch #(
		.WIDTH(1)
	) u_local_mbox (
		.clock(clock),
		.nrst(nrst),
		.set(lie_set),
		.clr(lie_clr),
		.q(lie_st)
	);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lie_en_reg <= 1'b0;
		end else if (local_lie_wr) begin
			lie_en_reg <= local_wdata[`LIE_MBOX_EN_BIT];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			local_irq <= 1'b0;
		end else begin
			local_irq <= lie_st && lie_en_reg;
		end
	end

	// registered read data, one cycle after the read strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			host_rdata <= `RDATA_RESET;
		end else if (host_rd_en) begin
			host_rdata <= `RDATA_RESET;
			if (host_sel == host_irq_pkg::SEL_HIE) begin
				host_rdata[`EN_MSB:`EN_LSB] <= enable_reg;
				host_rdata[`ST_MSB:0] <= status;
			end else if (host_sel == host_irq_pkg::SEL_MBOX) begin
				host_rdata[`MBOX_B1_MSB:`MBOX_B0_LSB] <= mbox_reg;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			local_rdata <= `RDATA_RESET;
		end else if (local_rd_en) begin
			local_rdata <= `RDATA_RESET;
			if (local_sel == host_irq_pkg::SEL_MBOX) begin
				local_rdata[`MBOX_B1_MSB:`MBOX_B0_LSB] <= mbox_reg;
			end else if (local_sel == host_irq_pkg::SEL_LIE) begin
				local_rdata[`LIE_MBOX_EN_BIT] <= lie_en_reg;
				local_rdata[`LIE_MBOX_ST_BIT] <= lie_st;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	AST_ENABLE_WRITE: assert property (host_hie_wr |=>
		enable_reg == ($past(host_wdata[`EN_MSB:`EN_LSB]) & ~`ST_RSVD_MASK))
		else $error("enable field did not take the written value");
	AST_RSVD_ZERO: assert property (!status[2] && !enable_reg[2])
		else $error("reserved bit 2 not zero");
	AST_EXT_LATCH: assert property (evt_ext_signal ##1 !(host_hie_wr && host_wdata[4])
		|-> status[4] [*2])
		else $error("external signal event not held");
	AST_W1C: assert property (host_hie_wr && host_wdata[0] && !evt_local_ovf
		|=> !status[0])
		else $error("write one did not clear status bit 0");
	AST_W0_KEEP: assert property (host_hie_wr && !host_wdata[1] && status[1]
		|=> status[1])
		else $error("write zero changed status bit 1");
	AST_LIVE_MIRROR: assert property (##1 status[7:6] ==
		{$past(outbound_q_bit3), $past(inbound_q_bit3)})
		else $error("queue mirror bits wrong");
	AST_MBOX_IRQ_HOLD: assert property (lie_st && !lie_clr |=> lie_st)
		else $error("mailbox event dropped without local clear");
	AST_MBOX_RAISE: assert property (lie_set && lie_en_reg && !local_lie_wr
		|=> ##1 local_irq)
		else $error("local interrupt not raised two cycles after host bit 24");
	AST_SOFT_RESET: assert property (soft_rst && !lie_set && !host_hie_wr
		|=> !lie_st && $stable(enable_reg))
		else $error("soft reset effect wrong");
	AST_HOST_IRQ: assert property (##1 host_irq ==
		|($past(status) & $past(enable_reg)))
		else $error("host interrupt does not follow status and enable");

	COV_HOST_IRQ: cover property (evt_dma_done ##1 enable_reg[5] ##1 host_irq);
	COV_CLEAR: cover property (host_irq ##1 host_hie_wr ##2 !host_irq);
	COV_MBOX: cover property (lie_set ##[1:10] local_irq ##[1:10] !local_irq);
	COV_SET_CLR_SAME: cover property (host_hie_wr && host_wdata[9] && evt_master_abort);
endmodule : host_interrupt_and_mailbox

/* File: bench/event_model.sv */
// event sources on the far side: queues, dma engine, bus aborts and external line
`timescale 1ns/1ps
module event_model (
	input wire logic [9:0] fire,
	output logic [9:0] evt
);
	// the reserved slot 2 has no source behind it
	assign evt = fire & 10'h3FB;
endmodule : event_model

/* File: bench/host_interrupt_and_mailbox_tb_top.sv */
// self-checking bench for the host interrupt and mailbox block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module host_interrupt_and_mailbox_tb_top;
	logic clock, nrst, soft_rst, hw, hr, lw, lr, host_irq, local_irq;
	logic [11:0] ha, la;
	logic [31:0] hwd, lwd, hrd, lrd;
	logic [9:0] fire, evt;
	int bad_count, checks_done, cyc;
	event_model em (.fire(fire), .evt(evt));
	host_interrupt_and_mailbox uut (.clock(clock), .nrst(nrst), .soft_rst(soft_rst),
		.host_wr_en(hw), .host_rd_en(hr), .host_addr(ha), .host_wdata(hwd), .host_rdata(hrd),
		.local_wr_en(lw), .local_rd_en(lr), .local_addr(la), .local_wdata(lwd),
		.local_rdata(lrd), .evt_local_ovf(evt[0]), .evt_pci_ovf(evt[1]),
		.evt_l2h_mailbox(evt[3]), .evt_ext_signal(evt[4]), .evt_dma_done(evt[5]),
		.inbound_q_bit3(evt[6]), .outbound_q_bit3(evt[7]), .evt_target_abort(evt[8]),
		.evt_master_abort(evt[9]), .host_irq(host_irq), .local_irq(local_irq));
	initial begin
		clock = 0;
		forever #25 clock = ~clock;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	always @(posedge clock) begin
		cyc++;
		if (cyc > 3000) begin
			bad_count++;
			stop_test();
		end
	end
	// one access, launched at a falling edge, strobe dropped at the next one, then one idle cycle
	task acc(input bit h, input bit w, input logic [11:0] a, input logic [31:0] d);
		if (h) begin
			{hw, hr, ha, hwd} = {w, !w, a, d};
		end else begin
			{lw, lr, la, lwd} = {w, !w, a, d};
		end
		@(negedge clock);
		{hw, hr, lw, lr} = '0;
		@(negedge clock);
	endtask : acc
	task rd(input bit h, input logic [11:0] a, input logic [31:0] e, input string n);
		acc(h, 0, a, 32'h0);
		`CHK(n, e, h ? hrd : lrd)
	endtask : rd
	task pulse(input logic [9:0] f, input logic [9:0] hold);
		fire = f;
		@(negedge clock);
		fire = hold;
		repeat (2) @(negedge clock);
	endtask : pulse
	initial begin
		{soft_rst, hw, hr, lw, lr, nrst} = '0;
		{ha, la, hwd, lwd, fire} = '0;
		repeat (4) @(negedge clock);
		nrst = 1;
		@(negedge clock);
		rd(1, 12'h4E4, 32'h0, "hie reset");
		rd(1, 12'h4E8, 32'h0, "mbox reset");
		acc(1, 1, 12'h100, 32'hFFFFFFFF);
		rd(1, 12'h100, 32'h0, "unmapped");
		acc(1, 1, 12'h4E4, 32'h03FF0000);
		rd(1, 12'h4E4, 32'h03FB0000, "enables");
		$display("test enables done");
		pulse(10'h3FF, 10'h0C0);
		rd(1, 12'h4E4, 32'h03FB03FB, "all events");
		`CHK("host_irq", 1'h1, host_irq)
		acc(1, 1, 12'h4E4, 32'h03FF0000);
		rd(1, 12'h4E4, 32'h03FB03FB, "w0 keep");
		acc(1, 1, 12'h4E4, 32'h03FF03FF);
		rd(1, 12'h4E4, 32'h03FB00C0, "w1c");
		pulse(10'h000, 10'h000);
		rd(1, 12'h4E4, 32'h03FB0000, "live mirror");
		`CHK("host_irq off", 1'h0, host_irq)
		$display("test events done");
		acc(1, 1, 12'h4E4, 32'h0);
		pulse(10'h010, 10'h000);
		`CHK("masked irq", 1'h0, host_irq)
		acc(1, 1, 12'h4E4, 32'h00100000);
		rd(1, 12'h4E4, 32'h00100010, "ext held");
		`CHK("ext irq", 1'h1, host_irq)
		$display("test external done");
		acc(0, 1, 12'h4F4, 32'h00080000);
		acc(1, 1, 12'h4E8, 32'h0100ABCD);
		rd(0, 12'h4E8, 32'h0000ABCD, "mbox bytes");
		rd(0, 12'h4F4, 32'h00080008, "local status");
		`CHK("local_irq", 1'h1, local_irq)
		rd(1, 12'h4E8, 32'h0000ABCD, "mbox host view");
		soft_rst = 1;
		@(negedge clock);
		soft_rst = 0;
		rd(0, 12'h4F4, 32'h00080000, "soft local");
		rd(1, 12'h4E4, 32'h00100010, "soft host");
		`CHK("local_irq soft", 1'h0, local_irq)
		acc(1, 1, 12'h4E8, 32'h01000000);
		acc(0, 1, 12'h4F4, 32'h00080008);
		rd(0, 12'h4F4, 32'h00080000, "local clear");
		rd(0, 12'h4E8, 32'h0, "mbox rewritten");
		$display("test mailbox done");
		nrst = 0;
		@(negedge clock);
		nrst = 1;
		@(negedge clock);
		rd(1, 12'h4E4, 32'h0, "second reset");
		$display("test second reset done");
		stop_test();
	end
endmodule : host_interrupt_and_mailbox_tb_top
